// *** hw/motion_state_defs.vh ***
// Constants for the stepper motion state controller.
`ifndef MOTION_STATE_DEFS_VH
`define MOTION_STATE_DEFS_VH
`define ADDR_CTRL        8'h00
`define ADDR_CMD         8'h04
`define ADDR_TARGET      8'h08
`define ADDR_ACTUAL      8'h0C
`define ADDR_SECURE      8'h10
`define ADDR_EVENT       8'h14
`define ADDR_STATUS      8'h18
`define ADDR_DUAL        8'h1C
`define CTRL_BOOST_N     0
`define CTRL_PWM_RATE    1
`define CTRL_DITHER      2
`define CTRL_SLEEP_PERM  3
`define CTRL_ACC_SHAPE   4
`define CTRL_SETTLE_LSB  5
`define CTRL_RESET       32'h0000_0001
`define CMD_POS_SET      4'h1
`define CMD_POS_SHORT    4'h2
`define CMD_SAFE_POS     4'h3
`define CMD_SHORT_STAT   4'h4
`define CMD_FULL_STAT    4'h5
`define CMD_SLEEP        4'h6
`define CMD_RAMP_HALT    4'h7
`define CMD_ABRUPT_HALT  4'h8
`define CMD_DUAL_MOVE    4'h9
`define CMD_MOTOR_PARAM  4'hA
`define CMD_ID_ASSIGN    4'hB
`define CMD_BUS_TIMEOUT  4'hF
`define SEC_DISABLED     11'h400
`define ST_STANDBY       4'h0
`define ST_STOPPED       4'h1
`define ST_MOVING        4'h2
`define ST_DUAL          4'h3
`define ST_RAMP_HALT     4'h4
`define ST_ABRUPT_HALT   4'h5
`define ST_RAMP_HALTED   4'h6
`define ST_SHUTDOWN      4'h7
`define ST_SLEEP         4'h8
`define PWM_SLOW_HZ      22800
`define PWM_FAST_HZ      45600
`define CLK_HZ           40000000
`define SETTLE_UNIT      16'h0100
`endif

// *** hw/stepper_motion_state_control.v ***
// Stepper motion state controller with AXI4-Lite register access.
`timescale 1ns/10ps
`include "motion_state_defs.vh"
module stepper_motion_state_control #(
    parameter POS_W = 16
) (
    input  wire        i_clk,
    input  wire        i_resetn,
    input  wire        i_ce,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output wire [1:0]  s_axi_bresp,
    output wire        s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0]  s_axi_rresp,
    output wire        s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        i_motion_done,
    input  wire        i_step_tick,
    input  wire        i_thermal_sd,
    input  wire        i_temp_warn,
    input  wire        i_temp_cold,
    input  wire        i_supply_ok,
    input  wire [1:0]  i_bridge_drop,
    input  wire        i_undervolt_mode,
    output wire [3:0]  o_state,
    output wire        o_bridge_hiz,
    output wire [1:0]  o_bridge_off,
    output wire        o_run_current,
    output wire        o_boost_active,
    output wire        o_pwm_clk,
    output wire        o_profile_sel
);
    // Register storage and bus handshake state.
    reg [31:0]      ctrl_ff;
    reg [POS_W-1:0] target_ff, actual_ff, dual_pos_ff, dual_run_ff;
    reg [10:0]      secure_ff;
    reg [3:0]       state_ff, nxt_state;
    reg             sleep_req_ff, halt_mark_ff, thermal_ff, short_ff, step_loss_ff, seen_full_ff;
    reg [1:0]       bridge_off_ff;
    reg             dual_phase_ff, settle_ff;
    reg [15:0]      settle_cnt_ff;
    reg [3:0]       cmd_ff;
    reg             cmd_vld_ff;
    reg [7:0]       awaddr_ff, araddr_ff;
    reg             aw_ff, w_ff, bvalid_ff, rvalid_ff;
    reg [31:0]      wdata_ff, rdata_ff;
    reg [1:0]       rresp_ff, bresp_ff;
    reg             wake_ff;
    reg [15:0]      pwm_cnt_ff;
    reg             pwm_ff;
    reg [7:0]       lfsr_ff;
    wire            soft_rst = wake_ff;
    wire            do_write = aw_ff & w_ff & ~bvalid_ff;
    wire            secure_en = (secure_ff != `SEC_DISABLED);
    wire [POS_W-1:0] secure_pos = {{(POS_W-11){secure_ff[10]}}, secure_ff};
    wire            sleep_permit = ctrl_ff[`CTRL_SLEEP_PERM];
    wire [POS_W-1:0] unit_step = {{(POS_W-1){1'b0}}, 1'b1};
    wire            cmd_live = cmd_vld_ff & (state_ff != `ST_SLEEP);

    assign s_axi_awready = ~aw_ff & ~bvalid_ff;
    assign s_axi_wready  = ~w_ff & ~bvalid_ff;
    assign s_axi_bvalid  = bvalid_ff;
    assign s_axi_bresp   = bresp_ff;
    assign s_axi_arready = ~rvalid_ff;
    assign s_axi_rvalid  = rvalid_ff;
    assign s_axi_rdata   = rdata_ff;
    assign s_axi_rresp   = rresp_ff;

    // Write channel: address and data captured in either order, answered once both are in.
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            aw_ff     <= 1'b0;
            w_ff      <= 1'b0;
            awaddr_ff <= 8'h00;
            wdata_ff  <= 32'h0000_0000;
            bvalid_ff <= 1'b0;
            bresp_ff  <= 2'h0;
        end else if (i_ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_ff     <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_ff     <= 1'b1;
                wdata_ff <= s_axi_wdata;
            end
            if (do_write) begin
                aw_ff     <= 1'b0;
                w_ff      <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff  <= (awaddr_ff > `ADDR_DUAL || awaddr_ff[1:0] != 2'h0) ? 2'h2 : 2'h0;
            end else if (bvalid_ff && s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    // Read channel: one cycle to data, held until taken.
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= 32'h0000_0000;
            rresp_ff  <= 2'h0;
        end else if (i_ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                rvalid_ff <= 1'b1;
                rresp_ff  <= 2'h0;
                case (s_axi_araddr)
                    `ADDR_CTRL:   rdata_ff <= ctrl_ff;
                    `ADDR_CMD:    rdata_ff <= {28'h0000000, cmd_ff};
                    `ADDR_TARGET: rdata_ff <= {{(32-POS_W){target_ff[POS_W-1]}}, target_ff};
                    `ADDR_ACTUAL: rdata_ff <= {{(32-POS_W){actual_ff[POS_W-1]}}, actual_ff};
                    `ADDR_SECURE: rdata_ff <= {21'h000000, secure_ff};
                    `ADDR_STATUS: rdata_ff <= {19'h00000, bridge_off_ff, dual_phase_ff, secure_en,
                                              step_loss_ff, short_ff, thermal_ff, halt_mark_ff,
                                              sleep_req_ff, state_ff};
                    `ADDR_DUAL:   rdata_ff <= {{(32-POS_W){dual_pos_ff[POS_W-1]}}, dual_pos_ff};
                    `ADDR_EVENT:  rdata_ff <= 32'h0000_0000;
                    default: begin
                        rdata_ff <= 32'h0000_0000;
                        rresp_ff <= 2'h2;
                    end
                endcase
            end else if (rvalid_ff && s_axi_rready) begin
                rvalid_ff <= 1'b0;
            end
        end
    end

    // State priority encoder; unlisted combinations hold the state.
    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            `ST_STANDBY: begin
                if (thermal_ff || short_ff)
                    nxt_state = `ST_SHUTDOWN;
                else if (sleep_req_ff)
                    nxt_state = `ST_SLEEP;
                else if (cmd_live && cmd_ff == `CMD_DUAL_MOVE)
                    nxt_state = `ST_DUAL;
                else if (target_ff != actual_ff)
                    nxt_state = `ST_MOVING;
            end
            `ST_STOPPED: begin
                if (thermal_ff || short_ff)
                    nxt_state = `ST_SHUTDOWN;
                else if (cmd_live && cmd_ff == `CMD_DUAL_MOVE)
                    nxt_state = `ST_DUAL;
                else if (sleep_req_ff && sleep_permit &&
                         (!secure_en || actual_ff == secure_pos || halt_mark_ff))
                    nxt_state = `ST_SLEEP;
                else if (sleep_req_ff && sleep_permit)
                    nxt_state = `ST_MOVING;
                else if (target_ff != actual_ff)
                    nxt_state = `ST_MOVING;
            end
            `ST_MOVING, `ST_DUAL: begin
                if (i_bridge_drop != 2'b00)
                    nxt_state = `ST_ABRUPT_HALT;
                else if (cmd_live && cmd_ff == `CMD_ABRUPT_HALT)
                    nxt_state = `ST_ABRUPT_HALT;
                else if (thermal_ff || (cmd_live && cmd_ff == `CMD_RAMP_HALT) ||
                         (sleep_req_ff && !secure_en && state_ff == `ST_MOVING))
                    nxt_state = `ST_RAMP_HALT;
                else if (i_motion_done && !(state_ff == `ST_DUAL && !dual_phase_ff))
                    nxt_state = `ST_STOPPED;
            end
            `ST_RAMP_HALT: begin
                if (cmd_live && cmd_ff == `CMD_ABRUPT_HALT)
                    nxt_state = `ST_ABRUPT_HALT;
                else if (i_motion_done)
                    nxt_state = `ST_STOPPED;
            end
            `ST_ABRUPT_HALT: begin
                if (i_motion_done)
                    nxt_state = `ST_STOPPED;
            end
            `ST_RAMP_HALTED: begin
                if (thermal_ff)
                    nxt_state = `ST_SHUTDOWN;
            end
            `ST_SHUTDOWN: begin
                // leave to stopped only with both flags clear; a sleep request leaves to sleep with flags set.
                if (!thermal_ff && !short_ff && cmd_live &&
                    (cmd_ff == `CMD_SHORT_STAT || cmd_ff == `CMD_FULL_STAT))
                    nxt_state = `ST_STOPPED;
                else if (sleep_req_ff)
                    nxt_state = `ST_SLEEP;
            end
            `ST_SLEEP: nxt_state = `ST_SLEEP;
            default:   nxt_state = `ST_STANDBY;
        endcase
    end

    // Sleep is left by any bus activity; that wake pulses a reinitialisation of the core state, flags and position registers.
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn)
            wake_ff <= 1'b0;
        else if (i_ce)
            wake_ff <= (state_ff == `ST_SLEEP) && (s_axi_awvalid || s_axi_arvalid) && !wake_ff;
    end

    // Core state, flags and position registers.
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_ff      <= `ST_STANDBY;
            ctrl_ff       <= `CTRL_RESET;
            target_ff     <= {POS_W{1'b0}};
            actual_ff     <= {POS_W{1'b0}};
            dual_pos_ff   <= {POS_W{1'b0}};
            dual_run_ff   <= {POS_W{1'b0}};
            secure_ff     <= `SEC_DISABLED;
            sleep_req_ff  <= 1'b0;
            halt_mark_ff  <= 1'b0;
            thermal_ff    <= 1'b0;
            short_ff      <= 1'b0;
            step_loss_ff  <= 1'b0;
            seen_full_ff  <= 1'b0;
            bridge_off_ff <= 2'b00;
            dual_phase_ff <= 1'b0;
            cmd_ff        <= 4'h0;
            cmd_vld_ff    <= 1'b0;
            settle_ff     <= 1'b0;
            settle_cnt_ff <= 16'h0000;
        end else if (i_ce && soft_rst) begin
            state_ff      <= `ST_STANDBY;
            ctrl_ff       <= `CTRL_RESET;
            target_ff     <= {POS_W{1'b0}};
            actual_ff     <= {POS_W{1'b0}};
            dual_pos_ff   <= {POS_W{1'b0}};
            dual_run_ff   <= {POS_W{1'b0}};
            secure_ff     <= `SEC_DISABLED;
            sleep_req_ff  <= 1'b0;
            halt_mark_ff  <= 1'b0;
            thermal_ff    <= 1'b0;
            short_ff      <= 1'b0;
            step_loss_ff  <= 1'b0;
            seen_full_ff  <= 1'b0;
            bridge_off_ff <= 2'b00;
            dual_phase_ff <= 1'b0;
            cmd_ff        <= 4'h0;
            cmd_vld_ff    <= 1'b0;
            settle_ff     <= 1'b0;
            settle_cnt_ff <= 16'h0000;
        end else if (i_ce) begin
            state_ff   <= nxt_state;
            cmd_vld_ff <= 1'b0;
            if (i_step_tick && actual_ff != target_ff)
                actual_ff <= (target_ff > actual_ff) ? actual_ff + unit_step : actual_ff - unit_step;
            // Register writes; commands are taken as one-cycle events.
            if (do_write) begin
                case (awaddr_ff)
                    `ADDR_CTRL: begin
                        // profile bit only accepted outside a normal move.
                        if (state_ff == `ST_MOVING)
                            ctrl_ff <= {wdata_ff[31:5], ctrl_ff[4], wdata_ff[3:0]};
                        else
                            ctrl_ff <= wdata_ff;
                    end
                    `ADDR_CMD: begin
                        cmd_ff     <= wdata_ff[3:0];
                        cmd_vld_ff <= 1'b1;
                    end
                    `ADDR_TARGET: dual_run_ff <= wdata_ff[POS_W-1:0];
                    `ADDR_SECURE: secure_ff   <= wdata_ff[10:0];
                    `ADDR_DUAL:   dual_pos_ff <= wdata_ff[POS_W-1:0];
                    default: ;
                endcase
            end
            // position commands run even with lost steps.
            if (cmd_live && (cmd_ff == `CMD_POS_SET || cmd_ff == `CMD_POS_SHORT) &&
                state_ff != `ST_SHUTDOWN)
                target_ff <= dual_run_ff;
            if (cmd_live && cmd_ff == `CMD_SAFE_POS && secure_en && state_ff != `ST_SHUTDOWN)
                target_ff <= secure_pos;
            // sleep request set wins over clear.
            if (cmd_live && (cmd_ff == `CMD_SLEEP || cmd_ff == `CMD_BUS_TIMEOUT))
                sleep_req_ff <= 1'b1;
            else if (cmd_live && cmd_ff != `CMD_ID_ASSIGN)
                sleep_req_ff <= 1'b0;
            if ((state_ff == `ST_RAMP_HALT || state_ff == `ST_ABRUPT_HALT) && nxt_state != state_ff)
                halt_mark_ff <= 1'b1;
            else if (state_ff == `ST_STOPPED)
                halt_mark_ff <= 1'b0;
            // halt completion copies actual into target.
            if ((state_ff == `ST_RAMP_HALT || state_ff == `ST_ABRUPT_HALT) && i_motion_done)
                target_ff <= actual_ff;
            if (state_ff == `ST_STOPPED && nxt_state == `ST_MOVING && sleep_req_ff)
                target_ff <= secure_pos;
            // shutdown entry copies actual to target unless in undervolt mode.
            if (nxt_state == `ST_SHUTDOWN && state_ff != `ST_SHUTDOWN && !i_undervolt_mode)
                target_ff <= actual_ff;
            // two-phase move starts with its own target.
            if (state_ff != `ST_DUAL && nxt_state == `ST_DUAL) begin
                dual_phase_ff <= 1'b0;
                target_ff     <= dual_pos_ff;
            end else if (state_ff == `ST_DUAL && i_motion_done && !dual_phase_ff) begin
                dual_phase_ff <= 1'b1;
                target_ff     <= dual_run_ff;
            end else if (state_ff != `ST_DUAL) begin
                dual_phase_ff <= 1'b0;
            end
            // boost bit forced off when warm.
            if (i_temp_warn)
                ctrl_ff[`CTRL_BOOST_N] <= 1'b1;
            // error flags clear after full query under normal conditions.
            if (i_thermal_sd)
                thermal_ff <= 1'b1;
            else if (seen_full_ff && !i_temp_warn && i_supply_ok && i_bridge_drop == 2'b00)
                thermal_ff <= 1'b0;
            // coil defect flag and bridge switch-off.
            if (i_bridge_drop != 2'b00) begin
                short_ff      <= 1'b1;
                bridge_off_ff <= bridge_off_ff | i_bridge_drop;
            end else if (seen_full_ff && !i_thermal_sd && i_supply_ok) begin
                short_ff      <= 1'b0;
                bridge_off_ff <= 2'b00;
            end
            // The query is latched after the clear, so a query in a quiet cycle is not lost.
            if (seen_full_ff && !i_thermal_sd && !i_temp_warn && i_supply_ok && i_bridge_drop == 2'b00)
                seen_full_ff <= 1'b0;
            if (cmd_live && cmd_ff == `CMD_FULL_STAT)
                seen_full_ff <= 1'b1;
            // lost-step flag cleared by status queries.
            if (i_bridge_drop != 2'b00 && (state_ff == `ST_MOVING || state_ff == `ST_DUAL))
                step_loss_ff <= 1'b1;
            else if (cmd_live && (cmd_ff == `CMD_SHORT_STAT || cmd_ff == `CMD_FULL_STAT))
                step_loss_ff <= 1'b0;
            if ((state_ff == `ST_MOVING || state_ff == `ST_DUAL) && nxt_state == `ST_STOPPED) begin
                settle_ff     <= 1'b1;
                settle_cnt_ff <= `SETTLE_UNIT << ctrl_ff[`CTRL_SETTLE_LSB+1:`CTRL_SETTLE_LSB];
            end else if (settle_ff) begin
                if (settle_cnt_ff == 16'h0001)
                    settle_ff <= 1'b0;
                settle_cnt_ff <= settle_cnt_ff - 16'h0001;
            end
        end
    end

    // PWM clock: rate select picks the divider; dither perturbs it with a small LFSR.
    localparam integer DIV_SLOW_N = `CLK_HZ / (2 * `PWM_SLOW_HZ);
    localparam integer DIV_FAST_N = `CLK_HZ / (2 * `PWM_FAST_HZ);
    localparam [15:0]  DIV_SLOW   = DIV_SLOW_N[15:0];
    localparam [15:0]  DIV_FAST   = DIV_FAST_N[15:0];
    wire [15:0] pwm_div = (ctrl_ff[`CTRL_PWM_RATE] ? DIV_FAST : DIV_SLOW) +
                          (ctrl_ff[`CTRL_DITHER] ? {12'h000, lfsr_ff[3:0]} : 16'h0000);
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            pwm_cnt_ff <= 16'h0000;
            pwm_ff     <= 1'b0;
            lfsr_ff    <= 8'h01;
        end else if (i_ce) begin
            if (pwm_cnt_ff >= pwm_div) begin
                pwm_cnt_ff <= 16'h0000;
                pwm_ff     <= ~pwm_ff;
                lfsr_ff    <= {lfsr_ff[6:0], lfsr_ff[7] ^ lfsr_ff[5] ^ lfsr_ff[4] ^ lfsr_ff[3]};
            end else begin
                pwm_cnt_ff <= pwm_cnt_ff + 16'h0001;
            end
        end
    end

    assign o_state        = state_ff;
    assign o_bridge_hiz   = (state_ff == `ST_SHUTDOWN) || (state_ff == `ST_SLEEP);
    assign o_bridge_off   = bridge_off_ff;
    // run current from motion start until settle ends; a halted move drops it at halt completion without settle.
    assign o_run_current  = (state_ff == `ST_MOVING) || (state_ff == `ST_DUAL) ||
                            (state_ff == `ST_RAMP_HALT) || (state_ff == `ST_ABRUPT_HALT) || settle_ff;
    assign o_boost_active = ~ctrl_ff[`CTRL_BOOST_N] & i_temp_cold & ~i_temp_warn;
    assign o_pwm_clk      = pwm_ff;
    // profile forced to 1 in phase two.
    assign o_profile_sel  = ctrl_ff[`CTRL_ACC_SHAPE] | (state_ff == `ST_DUAL && dual_phase_ff);
endmodule

// *** tb/axi_lite_master_model.sv ***
// Register bus master model standing in for the far-side controller.
`timescale 1ns/10ps
module axi_lite_master_model (
    input  wire        i_clk, i_resetn, i_go, i_we,
    input  wire [7:0]  i_addr,
    input  wire [31:0] i_wdata,
    output reg         o_done,
    output reg  [31:0] o_rdata,
    output reg  [1:0]  o_resp,
    output reg  [7:0]  s_axi_awaddr, s_axi_araddr,
    output reg  [31:0] s_axi_wdata,
    output wire [3:0]  s_axi_wstrb,
    output reg         s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready,
    input  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid,
    input  wire [1:0]  s_axi_bresp, s_axi_rresp,
    input  wire [31:0] s_axi_rdata
);
    assign s_axi_wstrb = 4'hF;
    // Each valid is held until its own ready is sampled, so the slave may take them in any order.
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, o_done} <= 6'h00;
            {s_axi_awaddr, s_axi_araddr, s_axi_wdata, o_rdata, o_resp} <= 82'h0;
        end else begin
            o_done <= 1'b0;
            if (i_go) begin
                {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{i_we}};
                {s_axi_arvalid, s_axi_rready} <= {2{!i_we}};
                s_axi_awaddr <= i_addr;
                s_axi_araddr <= i_addr;
                s_axi_wdata <= i_wdata;
            end
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_bready && s_axi_bvalid) begin
                {s_axi_bready, o_resp, o_done} <= {1'b0, s_axi_bresp, 1'b1};
            end
            if (s_axi_rready && s_axi_rvalid) begin
                {s_axi_rready, o_rdata, o_resp, o_done} <= {1'b0, s_axi_rdata, s_axi_rresp, 1'b1};
            end
        end
    end
endmodule

// *** tb/motion_state_monitor.sv ***
// Checker watching the motion state controller ports.
`timescale 1ns/10ps
`include "motion_state_defs.vh"
module motion_state_monitor (
    input wire       i_clk, i_resetn, i_ce, i_motion_done, i_thermal_sd, i_temp_warn,
    input wire [1:0] i_bridge_drop,
    input wire [3:0] o_state,
    input wire       o_bridge_hiz,
    input wire [1:0] o_bridge_off,
    input wire       o_run_current, o_boost_active
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    property p_rst; $rose(i_resetn) |-> o_state == `ST_STANDBY; endproperty
    a_rst: assert property (p_rst) else $error("not standby");
    property p_done; i_ce && i_motion_done && !i_thermal_sd && i_bridge_drop == 2'h0 &&
        (o_state == `ST_MOVING || o_state == `ST_DUAL) |=> o_state == `ST_STOPPED; endproperty
    a_done: assert property (p_done) else $error("no stop");
    property p_hiz; o_state == `ST_SHUTDOWN |-> o_bridge_hiz; endproperty
    a_hiz: assert property (p_hiz) else $error("bridge driven");
    property p_nosleep; o_state == `ST_MOVING |=> o_state != `ST_SLEEP; endproperty
    a_nosleep: assert property (p_nosleep) else $error("direct sleep");
    property p_warn; i_ce && i_temp_warn |=> !o_boost_active; endproperty
    a_warn: assert property (p_warn) else $error("boost hot");
    property p_off; i_ce && i_bridge_drop[0] |-> ##[1:2] o_bridge_off[0]; endproperty
    a_off: assert property (p_off) else $error("bridge on");
    property p_run; o_state == `ST_STOPPED ##1 o_state == `ST_MOVING |-> o_run_current; endproperty
    a_run: assert property (p_run) else $error("no run current");
    property p_shut; i_thermal_sd && o_state == `ST_SHUTDOWN |=> o_state inside {`ST_SHUTDOWN, `ST_SLEEP}; endproperty
    a_shut: assert property (p_shut) else $error("left shutdown");
endmodule
bind stepper_motion_state_control motion_state_monitor motion_state_monitor_i (.*);

// *** tb/stepper_motion_state_control_tb.sv ***
// Self-checking bench for the stepper motion state controller.
`timescale 1ns/10ps
`include "motion_state_defs.vh"
module stepper_motion_state_control_tb;
    logic i_clk = 0, i_resetn = 0, i_go = 0, i_we = 0, i_ce = 1, i_motion_done = 0, i_step_tick = 0;
    logic i_thermal_sd = 0, i_temp_warn = 0, i_temp_cold = 0, i_supply_ok = 1, i_undervolt_mode = 0;
    logic [1:0] i_bridge_drop = 2'h0;
    logic [7:0] i_addr = 8'h00;
    logic [31:0] i_wdata = 32'h0;
    wire [7:0] s_axi_awaddr, s_axi_araddr;
    wire [31:0] s_axi_wdata, s_axi_rdata, o_rdata;
    wire [3:0] s_axi_wstrb, o_state;
    wire [1:0] s_axi_bresp, s_axi_rresp, o_resp, o_bridge_off;
    wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready, o_done;
    wire s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, o_bridge_hiz, o_run_current;
    wire o_boost_active, o_pwm_clk, o_profile_sel;
    integer num_errors = 0, num_checks = 0, k, j, d, seed;
    stepper_motion_state_control stepper_motion_state_control_i (.*);
    axi_lite_master_model axi_lite_master_model_i (.*);
    // Free-running 40 MHz clock.
    always #12.5 i_clk = ~i_clk;
    task end_sim;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks = num_checks + 1;
        if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("BAD %0t saw %h want %h", $time, seen, exp);
        end
    endtask
    // One bus transfer; a missing answer ends the run.
    task bus(input logic w, input logic [7:0] a, input logic [31:0] v);
        integer n;
        @(posedge i_clk);
        {i_go, i_we, i_addr, i_wdata} <= {1'b1, w, a, v};
        @(posedge i_clk);
        i_go <= 1'b0;
        for (n = 0; n < 40 && o_done !== 1'b1; n = n + 1) @(negedge i_clk);
        chk(o_done, 1);
        if (o_done !== 1'b1) end_sim;
    endtask
    task wait_st(input logic [3:0] s);
        integer n;
        for (n = 0; n < 200 && o_state !== s; n = n + 1) @(negedge i_clk);
        chk(o_state, s);
    endtask
    // Step pulses move the actual position, then the motion reports done.
    task steps(input integer n);
        repeat (n) begin
            @(posedge i_clk) i_step_tick <= 1'b1;
            @(posedge i_clk) i_step_tick <= 1'b0;
        end
        @(posedge i_clk) i_motion_done <= 1'b1;
        @(posedge i_clk) i_motion_done <= 1'b0;
    endtask
    initial begin
        seed = $urandom(32'h6E75);
        repeat (6) @(posedge i_clk);
        i_resetn <= 1'b1;
        @(negedge i_clk) chk(o_state, `ST_STANDBY);
        for (d = 0; d < 2000 && o_pwm_clk !== 1'b1; d = d + 1) @(negedge i_clk);
        for (d = 0; d < 2000 && o_pwm_clk === 1'b1; d = d + 1) @(negedge i_clk);
        chk(d, `CLK_HZ / (2 * `PWM_SLOW_HZ) + 1);
        bus(0, `ADDR_CTRL, 0);
        chk(o_rdata, `CTRL_RESET);
        bus(0, 8'hFC, 0);
        chk(o_resp, 2'h2);
        k = 2 + $urandom % 6;
        bus(1, `ADDR_TARGET, k);
        bus(1, `ADDR_CMD, `CMD_POS_SET);
        wait_st(`ST_MOVING);
        chk(o_run_current, 1);
        steps(k);
        wait_st(`ST_STOPPED);
        bus(1, `ADDR_TARGET, k + 40);
        bus(1, `ADDR_CMD, `CMD_POS_SET);
        wait_st(`ST_MOVING);
        j = 1 + $urandom % 4;
        bus(1, `ADDR_CMD, `CMD_RAMP_HALT);
        wait_st(`ST_RAMP_HALT);
        steps(j);
        wait_st(`ST_STOPPED);
        bus(0, `ADDR_TARGET, 0);
        chk(o_rdata, k + j);
        $display("motion test ended");
        d = 1 + $urandom % 3;
        @(posedge i_clk) i_bridge_drop <= d;
        wait_st(`ST_SHUTDOWN);
        chk(o_bridge_off & d, d);
        chk(o_bridge_hiz, 1);
        @(posedge i_clk) {i_thermal_sd, i_bridge_drop} <= 3'h4;
        bus(1, `ADDR_CMD, `CMD_FULL_STAT);
        repeat (4) @(negedge i_clk);
        chk(o_state, `ST_SHUTDOWN);
        @(posedge i_clk) i_thermal_sd <= 1'b0;
        bus(1, `ADDR_CMD, `CMD_FULL_STAT);
        wait_st(`ST_STOPPED);
        $display("fault test ended");
        bus(1, `ADDR_CTRL, 32'h10);
        chk(o_profile_sel, 1);
        @(posedge i_clk) i_temp_cold <= 1'b1;
        @(negedge i_clk) chk(o_boost_active, 1);
        @(posedge i_clk) i_temp_warn <= 1'b1;
        repeat (2) @(negedge i_clk);
        chk(o_boost_active, 0);
        @(posedge i_clk) i_temp_warn <= 1'b0;
        @(negedge i_clk) chk(o_boost_active, 0);
        @(posedge i_clk) i_temp_cold <= 1'b0;
        $display("boost test ended");
        bus(1, `ADDR_CMD, `CMD_SLEEP);
        repeat (8) @(negedge i_clk);
        chk(o_state, `ST_STOPPED);
        bus(1, `ADDR_CTRL, 32'h9);
        wait_st(`ST_SLEEP);
        bus(0, `ADDR_CTRL, 0);
        chk(o_rdata, 32'h9);
        chk(o_state, `ST_STANDBY);
        bus(0, `ADDR_CTRL, 0);
        chk(o_rdata, `CTRL_RESET);
        $display("sleep test ended");
        end_sim;
    end
endmodule
